// ===== imcr_pkg.sv
// shared constants, types and carriers of the margin/config register target
package imcr_pkg;
	// 7-bit target address is {ADDR_HI, strapped lsb}
	localparam logic [5:0] ADDR_HI = 6'h23;
	// pointer byte values
	localparam logic [7:0] REG0_OFF = 8'h00;
	localparam logic [7:0] REG1_OFF = 8'h01;
	// reset values
	localparam logic [7:0] REG0_RST = 8'h00;
	localparam logic [7:0] REG1_RST = 8'h00;
	// implemented bits; the rest read back as zero
	localparam logic [7:0] REG0_MASK = 8'h3f;
	localparam logic [7:0] REG1_MASK = 8'h5f;
	// field positions in the config register, and the margin field width
	localparam int PHASE_BIT = 6;
	localparam int DEADTIME_BIT = 4;
	localparam int OVP_BIT = 3;
	localparam int FREQ_LSB = 0;
	localparam int FREQ_W = 3;
	localparam int MARGIN_W = 6;
	// frequency step codes
	localparam logic [2:0] FREQ_NOM = 3'h0;
	localparam logic [2:0] FREQ_MAX = 3'h4;
	// margin step, in tenths of a millivolt (12.5 mV)
	localparam logic [6:0] MARGIN_STEP_TENTH_MV = 7'h7d;
	localparam int MARGIN_MV_W = 13;
	// bit counter value of the acknowledge slot
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// pointer saturates here: past the last register
	localparam logic [1:0] PTR_END = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_SKIP
	} imcr_state_e;

	// operating parameters handed to the regulation loops
	typedef struct packed {
		logic phaseSingle;
		logic deadtimeLgate;
		logic ovpAlt;
		logic [FREQ_W-1:0] freqSel;
		logic [MARGIN_W-1:0] marginCode;
		logic [MARGIN_MV_W-1:0] marginTenthMv;
	} imcr_cfg_s;
endpackage

// ===== imcr_sync.sv
// two-flop level synchroniser, one bit per lane
`timescale 1ns/1ns
module imcr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] stab_q;
	logic [W-1:0] stab_d;

	always_comb
	begin
		meta_d = din;
		stab_d = meta_q;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= '0;
			stab_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			stab_q <= stab_d;
		end
	end

	assign dout = stab_q;
endmodule

// ===== imcr_cfg_decode.sv
// decodes the two stored registers into operating parameters
`timescale 1ns/1ns
module imcr_cfg_decode (
	// stored register contents
	input wire logic [7:0] marginReg,
	input wire logic [7:0] configReg,
	// decoded parameters
	output imcr_pkg::imcr_cfg_s cfg
);
	logic [2:0] freqRaw;

	always_comb
	begin
		freqRaw = configReg[imcr_pkg::FREQ_LSB +: imcr_pkg::FREQ_W];
		cfg.phaseSingle = configReg[imcr_pkg::PHASE_BIT];
		cfg.deadtimeLgate = configReg[imcr_pkg::DEADTIME_BIT];
		cfg.ovpAlt = configReg[imcr_pkg::OVP_BIT];
		// undefined codes fall back to nominal
		cfg.freqSel = (freqRaw > imcr_pkg::FREQ_MAX) ?
			imcr_pkg::FREQ_NOM : freqRaw;
		// upper two bits never reach the offset
		cfg.marginCode = marginReg[imcr_pkg::MARGIN_W-1:0];
		cfg.marginTenthMv = 13'(cfg.marginCode) *
			13'(imcr_pkg::MARGIN_STEP_TENTH_MV);
	end
endmodule

// ===== imcr_top.sv
// two-wire target giving access to the margin and config registers
`timescale 1ns/1ns
module imcr_top (
	// system clock and reset
	input wire logic clk,
	input wire logic rstn,
	// serial link
	input wire logic sclClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// power-on detect and the shared strap/reset pin
	input wire logic porOk,
	input wire logic ssPinLow,
	input wire logic addrSelPin,
	// operating parameters
	output imcr_pkg::imcr_cfg_s cfg
);
	// link domain: capture each bit on the rising serial clock
	logic bitVal_q;
	logic bitVal_d;
	logic bitTog_q;
	logic bitTog_d;

	always_comb
	begin
		bitVal_d = sdaIn;
		bitTog_d = ~bitTog_q;
	end

	always_ff @(posedge sclClk or negedge rstn)
	begin
		if (!rstn)
		begin
			bitVal_q <= 1'b0;
			bitTog_q <= 1'b0;
		end
		else
		begin
			bitVal_q <= bitVal_d;
			bitTog_q <= bitTog_d;
		end
	end

	// pins and the bit toggle into the system domain
	logic sclS;
	logic sdaS;
	logic porS;
	logic ssLowS;
	logic addrSelS;
	logic togS;

	imcr_sync #(
		.W(6)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din({sclClk, sdaIn, porOk, ssPinLow, addrSelPin, bitTog_q}),
		.dout({sclS, sdaS, porS, ssLowS, addrSelS, togS})
	);

	// system domain state
	imcr_pkg::imcr_state_e state_q;
	imcr_pkg::imcr_state_e state_d;
	imcr_pkg::imcr_state_e pend_q;
	imcr_pkg::imcr_state_e pend_d;
	logic [3:0] bitCnt_q;
	logic [3:0] bitCnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic [1:0] ptr_q;
	logic [1:0] ptr_d;
	logic [7:0] reg0_q;
	logic [7:0] reg0_d;
	logic [7:0] reg1_q;
	logic [7:0] reg1_d;
	logic oe_q;
	logic oe_d;
	logic addrLsb_q;
	logic addrLsb_d;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic togPrev_q;
	logic porPrev_q;
	logic sdaOut_q;
	imcr_pkg::imcr_cfg_s cfg_q;
	imcr_pkg::imcr_cfg_s cfg_d;
	imcr_pkg::imcr_cfg_s decoded;

	logic startEv;
	logic stopEv;
	logic sclFall;
	logic bitEv;
	logic clearRegs;
	logic addrMatch;
	logic txBit;

	function automatic logic [1:0] nextPtr(input logic [1:0] p);
		nextPtr = (p == imcr_pkg::PTR_END) ? p : 2'(p + 2'h1);
	endfunction

	function automatic logic [7:0] readReg(input logic [1:0] p,
		input logic [7:0] r0, input logic [7:0] r1);
		unique case (p)
			2'h0: readReg = r0 & imcr_pkg::REG0_MASK;
			2'h1: readReg = r1 & imcr_pkg::REG1_MASK;
			default: readReg = 8'h00;
		endcase
	endfunction

	imcr_cfg_decode u_decode (
		.marginReg(reg0_q),
		.configReg(reg1_q),
		.cfg(decoded)
	);

	// bit toggle only changes while the clock is high and the data is
	// stable, so bitVal_q is safe to read once the toggle is seen
	assign bitEv = togS != togPrev_q;
	assign sclFall = sclPrev_q && !sclS;
	assign startEv = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopEv = sclS && sclPrev_q && !sdaPrev_q && sdaS;
	assign clearRegs = !porS || ssLowS;
	assign addrMatch = shift_q[7:1] == {imcr_pkg::ADDR_HI, addrLsb_q};
	assign txBit = tx_q[3'h7 - bitCnt_q[2:0]];

	always_comb
	begin
		state_d = state_q;
		pend_d = pend_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		reg0_d = reg0_q;
		reg1_d = reg1_q;
		oe_d = oe_q;
		if (!porS)
		begin
			// link ignored until power is good
			state_d = imcr_pkg::ST_IDLE;
			bitCnt_d = 4'h0;
			oe_d = 1'b0;
		end
		else if (startEv)
		begin
			state_d = imcr_pkg::ST_ADDR;
			bitCnt_d = 4'h0;
			oe_d = 1'b0;
		end
		else if (stopEv)
		begin
			// pointer survives for the following read
			state_d = imcr_pkg::ST_IDLE;
			bitCnt_d = 4'h0;
			oe_d = 1'b0;
		end
		else if (state_q != imcr_pkg::ST_IDLE && bitEv)
		begin
			if (bitCnt_q != imcr_pkg::ACK_SLOT)
			begin
				shift_d = {shift_q[6:0], bitVal_q};
				bitCnt_d = 4'(bitCnt_q + 4'h1);
			end
			else
			begin
				bitCnt_d = 4'h0;
				if (state_q == imcr_pkg::ST_RDATA)
				begin
					ptr_d = nextPtr(ptr_q);
					tx_d = readReg(nextPtr(ptr_q), reg0_q, reg1_q);
					if (bitVal_q)
						state_d = imcr_pkg::ST_SKIP;
				end
				else
					state_d = pend_q;
			end
		end
		else if (state_q != imcr_pkg::ST_IDLE && sclFall)
		begin
			if (state_q == imcr_pkg::ST_RDATA)
				oe_d = bitCnt_q != imcr_pkg::ACK_SLOT && !txBit;
			else if (bitCnt_q != imcr_pkg::ACK_SLOT)
				oe_d = 1'b0;
			else
			begin
				oe_d = 1'b0;
				pend_d = imcr_pkg::ST_SKIP;
				unique case (state_q)
					imcr_pkg::ST_ADDR:
						if (addrMatch)
						begin
							oe_d = 1'b1;
							if (shift_q[0])
							begin
								pend_d = imcr_pkg::ST_RDATA;
								tx_d = readReg(ptr_q, reg0_q, reg1_q);
							end
							else
								pend_d = imcr_pkg::ST_PTR;
						end
					imcr_pkg::ST_PTR:
						if (shift_q == imcr_pkg::REG0_OFF ||
							shift_q == imcr_pkg::REG1_OFF)
						begin
							oe_d = 1'b1;
							ptr_d = {1'b0, shift_q[0]};
							pend_d = imcr_pkg::ST_WDATA;
						end
					imcr_pkg::ST_WDATA:
						if (ptr_q != imcr_pkg::PTR_END)
						begin
							oe_d = 1'b1;
							if (ptr_q == 2'h0)
								reg0_d = shift_q & imcr_pkg::REG0_MASK;
							else
								reg1_d = shift_q & imcr_pkg::REG1_MASK;
							ptr_d = nextPtr(ptr_q);
							pend_d = imcr_pkg::ST_WDATA;
						end
					default:
						oe_d = 1'b0;
				endcase
			end
		end
		if (clearRegs)
		begin
			// register contents clear here; the applied cfg_q is zeroed as well
			reg0_d = imcr_pkg::REG0_RST;
			reg1_d = imcr_pkg::REG1_RST;
		end
	end

	always_comb
	begin
		cfg_d = cfg_q;
		addrLsb_d = addrLsb_q;
		if (porS && !porPrev_q)
			addrLsb_d = addrSelS;
		if (clearRegs)
			cfg_d = '0;
		else if (stopEv)
			cfg_d = decoded;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= imcr_pkg::ST_IDLE;
			pend_q <= imcr_pkg::ST_SKIP;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 2'h0;
			reg0_q <= imcr_pkg::REG0_RST;
			reg1_q <= imcr_pkg::REG1_RST;
			oe_q <= 1'b0;
			addrLsb_q <= 1'b0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			togPrev_q <= 1'b0;
			porPrev_q <= 1'b0;
			sdaOut_q <= 1'b0;
			cfg_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			pend_q <= pend_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			reg0_q <= reg0_d;
			reg1_q <= reg1_d;
			oe_q <= oe_d;
			addrLsb_q <= addrLsb_d;
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
			togPrev_q <= togS;
			porPrev_q <= porS;
			sdaOut_q <= 1'b0;
			cfg_q <= cfg_d;
		end
	end

	// open drain: the pin is only ever pulled low
	assign sdaOut = sdaOut_q;
	assign sdaOe = oe_q;
	assign cfg = cfg_q;

	property p_pinClear;
		@(posedge clk) disable iff (!rstn)
		ssLowS |=> reg0_q == 8'h00 && reg1_q == 8'h00 && cfg_q == '0;
	endproperty
	a_pinClear: assert property (p_pinClear)
		else $error("pin reset did not clear registers");

	property p_porClear;
		@(posedge clk) disable iff (!rstn)
		!porS |=> reg0_q == 8'h00 && reg1_q == 8'h00 && !oe_q;
	endproperty
	a_porClear: assert property (p_porClear)
		else $error("power-on drop did not clear registers");

	property p_applyAtStop;
		@(posedge clk) disable iff (!rstn)
		stopEv && !clearRegs |=>
			cfg_q.marginCode == $past(reg0_q[5:0]) &&
			cfg_q.phaseSingle == $past(reg1_q[6]);
	endproperty
	a_applyAtStop: assert property (p_applyAtStop)
		else $error("stored values not applied at stop");

	property p_holdUntilStop;
		@(posedge clk) disable iff (!rstn)
		!stopEv && !clearRegs |=> $stable(cfg_q);
	endproperty
	a_holdUntilStop: assert property (p_holdUntilStop)
		else $error("parameters changed without a stop");

	property p_addrHeld;
		@(posedge clk) disable iff (!rstn)
		porS && porPrev_q |=> $stable(addrLsb_q);
	endproperty
	a_addrHeld: assert property (p_addrHeld)
		else $error("address lsb changed while power good");

	property p_upperZero;
		@(posedge clk) disable iff (!rstn)
		reg0_q[7:6] == 2'h0 && reg1_q[7] == 1'b0 && reg1_q[5] == 1'b0;
	endproperty
	a_upperZero: assert property (p_upperZero)
		else $error("ignored bits stored as non-zero");

	property p_freqLegal;
		@(posedge clk) disable iff (!rstn)
		cfg_q.freqSel <= imcr_pkg::FREQ_MAX &&
			cfg_q.marginTenthMv == 13'(cfg_q.marginCode) * 13'h7d;
	endproperty
	a_freqLegal: assert property (p_freqLegal)
		else $error("frequency or margin decode out of range");

	property p_ackAddr;
		@(posedge clk) disable iff (!rstn)
		porS && !startEv && !stopEv && state_q == imcr_pkg::ST_ADDR &&
			sclFall && bitCnt_q == 4'h8 && addrMatch |=> oe_q;
	endproperty
	a_ackAddr: assert property (p_ackAddr)
		else $error("own address not acknowledged");

	property p_txBit;
		@(posedge clk) disable iff (!rstn)
		porS && !startEv && !stopEv && state_q == imcr_pkg::ST_RDATA &&
			sclFall && bitCnt_q < 4'h8 |=> oe_q == !$past(txBit);
	endproperty
	a_txBit: assert property (p_txBit)
		else $error("read data bit driven wrongly");

	property p_ptrAdvance;
		@(posedge clk) disable iff (!rstn)
		porS && !startEv && !stopEv && state_q == imcr_pkg::ST_WDATA &&
			sclFall && bitCnt_q == 4'h8 && ptr_q == 2'h0 |=>
			ptr_q == 2'h1 ##1 ptr_q == 2'h1 || !porS;
	endproperty
	a_ptrAdvance: assert property (p_ptrAdvance)
		else $error("pointer did not advance after write");
endmodule

// ===== imcr_i2c_master.sv
// two-wire bus master model driving the target's serial pins
`timescale 1ns/1ns
module imcr_i2c_master (
	// clock
	input wire logic clk,
	// bus
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	// scl stands high between frames; 15 clk cycles per phase leave room
	// for the target's synchronisers and its answer latency
	initial
	begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic hp();
		repeat (15) @(negedge clk);
	endtask
	task automatic start();
		sdaDrv = 1'b1;
		scl = 1'b1;
		hp();
		sdaDrv = 1'b0;
		hp();
		scl = 1'b0;
		hp();
	endtask
	task automatic stop();
		sdaDrv = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sdaDrv = 1'b1;
		hp();
	endtask
	// data changes only while scl is low
	task automatic bitx(input logic b, output logic r);
		sdaDrv = b;
		hp();
		scl = 1'b1;
		hp();
		r = sdaLine;
		scl = 1'b0;
		hp();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(nack, r);
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the margin and config register target
`timescale 1ns/1ns
module tb_top;
	logic clk;
	logic rstn;
	logic porOk;
	logic ssPinLow;
	logic addrSelPin;
	logic addrLsb;
	logic scl;
	logic sdaDrv;
	logic sdaOut;
	logic sdaOe;
	wire sdaLine;
	imcr_pkg::imcr_cfg_s cfg;
	int n_mismatch;
	int check_count;
	// written pairs; readback is the value under the stored-bit masks
	logic [7:0] rowTab [8][2] = '{'{8'hff, 8'hff}, '{8'h01, 8'h19},
		'{8'h3f, 8'h42}, '{8'h20, 8'h0b}, '{8'h15, 8'h4c},
		'{8'h00, 8'h05}, '{8'h2a, 8'h0e}, '{8'h00, 8'h00}};

	// open drain with pull-up: wired-and of both parties
	assign sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
	initial
		clk = 1'b0;
	always #20 clk = ~clk;

	imcr_top u_dut (.clk(clk), .rstn(rstn), .sclClk(scl),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .porOk(porOk),
		.ssPinLow(ssPinLow), .addrSelPin(addrSelPin), .cfg(cfg));
	imcr_i2c_master u_mst (.clk(clk), .scl(scl), .sdaDrv(sdaDrv),
		.sdaLine(sdaLine));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [24:0] e, g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] ctl(input logic rw);
		return {imcr_pkg::ADDR_HI, addrLsb, rw};
	endfunction
	function automatic imcr_pkg::imcr_cfg_s ecfg(input logic [7:0] a, b);
		ecfg.phaseSingle = b[6];
		ecfg.deadtimeLgate = b[4];
		ecfg.ovpAlt = b[3];
		ecfg.freqSel = (b[2:0] > 3'h4) ? 3'h0 : b[2:0];
		ecfg.marginCode = a[5:0];
		ecfg.marginTenthMv = 13'(a[5:0]) * 13'h007d;
	endfunction
	task automatic wr(input logic [7:0] by [4], input int n,
		output logic [3:0] ak);
		ak = 4'h0;
		u_mst.start();
		for (int i = 0; i < n; i++)
			u_mst.wbyte(by[i], ak[i]);
		u_mst.stop();
	endtask
	task automatic rd(input logic [7:0] p, input int n,
		output logic [15:0] d);
		logic [3:0] ak;
		logic a;
		wr('{ctl(1'b0), p, 8'h00, 8'h00}, 2, ak);
		chk("pointer acks", 25'h3, ak);
		u_mst.start();
		u_mst.wbyte(ctl(1'b1), a);
		chk("read ack", 25'h1, a);
		d = 16'h0000;
		if (n == 2)
			u_mst.rbyte(1'b0, d[15:8]);
		u_mst.rbyte(1'b1, d[7:0]);
		u_mst.stop();
	endtask
	task automatic waitcfg(input imcr_pkg::imcr_cfg_s e);
		for (int i = 0; i < 20 && cfg !== e; i++)
			@(negedge clk);
		chk("cfg", e, cfg);
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		$display("[FAIL] run length expected done seen hang");
		end_of_test();
	end

	initial
	begin
		logic [3:0] ak;
		logic [15:0] d;
		n_mismatch = 0;
		check_count = 0;
		rstn = 1'b0;
		porOk = 1'b1;
		ssPinLow = 1'b0;
		addrSelPin = 1'b0;
		addrLsb = 1'b0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (10) @(negedge clk);
		chk("cfg at reset", 25'h0, cfg);
		chk("sda drive level", 25'h0, sdaOut);
		rd(8'h00, 2, d);
		chk("regs at reset", 25'h0, d);
		for (int r = 0; r < 8; r++)
		begin
			wr('{ctl(1'b0), 8'h00, rowTab[r][0], rowTab[r][1]}, 4, ak);
			chk("write acks", 25'hf, ak);
			waitcfg(ecfg(rowTab[r][0], rowTab[r][1]));
			rd(8'h00, 2, d);
			chk("read both", {rowTab[r][0] & imcr_pkg::REG0_MASK,
				rowTab[r][1] & imcr_pkg::REG1_MASK}, d);
		end
		// second data byte runs past the last register
		wr('{ctl(1'b0), 8'h01, 8'h5a, 8'h33}, 4, ak);
		chk("overrun acks", 25'h7, ak);
		waitcfg(ecfg(8'h00, 8'h5a));
		rd(8'h01, 1, d);
		chk("read reg1", 25'h5a, d);
		wr('{{imcr_pkg::ADDR_HI, ~addrLsb, 1'b0}, 8'h00, 8'h00, 8'h00},
			1, ak);
		chk("foreign address", 25'h0, ak);
		wr('{ctl(1'b0), 8'h02, 8'h00, 8'h00}, 2, ak);
		chk("bad pointer", 25'h1, ak);
		wr('{ctl(1'b0), 8'h00, 8'h3f, 8'h5f}, 4, ak);
		waitcfg(ecfg(8'h3f, 8'h5f));
		ssPinLow = 1'b1;
		waitcfg(ecfg(8'h00, 8'h00));
		ssPinLow = 1'b0;
		rd(8'h00, 2, d);
		chk("pin clear", 25'h0, d);
		wr('{ctl(1'b0), 8'h00, 8'h3f, 8'h5f}, 4, ak);
		waitcfg(ecfg(8'h3f, 8'h5f));
		porOk = 1'b0;
		waitcfg(ecfg(8'h00, 8'h00));
		wr('{ctl(1'b0), 8'h00, 8'h3f, 8'h5f}, 4, ak);
		chk("write unpowered", 25'h0, ak);
		addrSelPin = 1'b1;
		repeat (2) @(negedge clk);
		porOk = 1'b1;
		repeat (10) @(negedge clk);
		// strap moves after the latch point and must not matter
		addrSelPin = 1'b0;
		addrLsb = 1'b1;
		repeat (10) @(negedge clk);
		rd(8'h00, 2, d);
		chk("por clear", 25'h0, d);
		wr('{{imcr_pkg::ADDR_HI, 1'b0, 1'b0}, 8'h00, 8'h00, 8'h00}, 1, ak);
		chk("old address", 25'h0, ak);
		end_of_test();
	end
endmodule
